// *** hdl/agen_pkg.sv ***
// Package with types and constants for the segment and effective address generator.
package agen_pkg;

    // Segment selection codes.
    typedef enum logic [2:0] {
        SEG_EXTRA = 3'h0,
        SEG_CODE = 3'h1,
        SEG_STACK = 3'h2,
        SEG_DATA = 3'h3,
        SEG_AUX_A = 3'h4,
        SEG_AUX_B = 3'h5
    } seg_sel_t;

    // Reference kinds delivered by the decoder.
    typedef enum logic [1:0] {
        REF_FETCH = 2'h0,
        REF_STACK = 2'h1,
        REF_DATA = 2'h2,
        REF_STR_DST = 2'h3
    } ref_kind_t;

    // Processor operating modes.
    typedef enum logic [1:0] {
        MODE_LEGACY = 2'h0,
        MODE_COMPAT = 2'h1,
        MODE_FLAT = 2'h2
    } cpu_mode_t;

    // Address size attribute.
    typedef enum logic [1:0] {
        ASZ_16 = 2'h0,
        ASZ_32 = 2'h1,
        ASZ_64 = 2'h2
    } addr_size_t;

    // Displacement size.
    typedef enum logic [1:0] {
        DISP_NONE = 2'h0,
        DISP_8 = 2'h1,
        DISP_16 = 2'h2,
        DISP_32 = 2'h3
    } disp_size_t;

    localparam int GPR_COUNT = 16;
    localparam int GPR_IDX_W = 4;
    localparam logic [3:0] GPR_IDX_A = 4'h0;
    localparam logic [3:0] GPR_IDX_B = 4'h3;
    localparam logic [3:0] GPR_IDX_SP = 4'h4;
    localparam logic [3:0] GPR_IDX_FP = 4'h5;
    localparam int SEG_COUNT = 6;
    localparam int SEL_W = 16;
    localparam int FAR_PTR_W = 48;
    localparam int FAR_OFS_W = 32;
    localparam logic [63:0] MASK_16 = 64'h0000_0000_0000_ffff;
    localparam logic [63:0] MASK_32 = 64'h0000_0000_ffff_ffff;
    localparam logic [63:0] MASK_64 = 64'hffff_ffff_ffff_ffff;

    // Operand request from the decoder.
    typedef struct packed {
        ref_kind_t kind;
        cpu_mode_t mode;
        logic code_d_flag;
        logic asz_prefix;
        logic ovr_valid;
        seg_sel_t ovr_seg;
        logic base_valid;
        logic [3:0] base_idx;
        logic index_valid;
        logic [3:0] index_idx;
        logic [1:0] scale_log2;
        disp_size_t disp_size;
        logic [31:0] disp;
        logic ip_rel;
        logic [63:0] next_ip;
    } agen_req_t;

    // Result handed to the memory access stage.
    typedef struct packed {
        seg_sel_t seg;
        addr_size_t asz;
        logic [63:0] eff_addr;
        logic [63:0] lin_addr;
        logic bad_index;
    } agen_rsp_t;

    // Explicit selector and far pointer load.
    typedef struct packed {
        logic from_reg;
        logic [15:0] sel_reg_val;
        logic [15:0] sel_mem_val;
        logic far_valid;
        logic [47:0] far_mem;
    } sel_req_t;

endpackage

// *** hdl/seg_ea_gen.sv ***
// Segment selection, effective address and linear address generation.
`timescale 1ns/1ps
`default_nettype none

module seg_ea_gen
    import agen_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire agen_req_t req,
    input wire logic [63:0] gpr_val [GPR_COUNT],
    input wire logic [63:0] seg_base [SEG_COUNT],
    input wire logic sel_valid,
    input wire sel_req_t sel_req,
    output logic rsp_valid,
    output agen_rsp_t rsp,
    output logic sel_out_valid,
    output logic [15:0] sel_out,
    output logic [31:0] far_offset
);

    // Sign extends a displacement of the given size to 64 bits.
    function automatic logic [63:0] sext_disp(input disp_size_t sz, input logic [31:0] d);
        logic [63:0] r;
        r = 64'h0;
        case (sz)
            DISP_8: r = {{56{d[7]}}, d[7:0]};
            DISP_16: r = {{48{d[15]}}, d[15:0]};
            DISP_32: r = {{32{d[31]}}, d};
            default: r = 64'h0;
        endcase
        return r;
    endfunction

    // Mask for an address size.
    function automatic logic [63:0] size_mask(input addr_size_t a);
        logic [63:0] m;
        m = MASK_64;
        case (a)
            ASZ_16: m = MASK_16;
            ASZ_32: m = MASK_32;
            default: m = MASK_64;
        endcase
        return m;
    endfunction

    // Register values narrowed to the address size, then sign extended,
    // so that a 32-bit negative component wraps correctly.
    function automatic logic [63:0] sized_reg(input addr_size_t a, input logic [63:0] v);
        logic [63:0] r;
        r = v;
        case (a)
            ASZ_16: r = {{48{v[15]}}, v[15:0]};
            ASZ_32: r = {{32{v[31]}}, v[31:0]};
            default: r = v;
        endcase
        return r;
    endfunction

    // Address size outside flat mode. The code segment default flag picks
    // 16 or 32 bits and the size prefix flips that choice for one instruction.
    function automatic addr_size_t legacy_asz(input logic d_flag, input logic pfx);
        addr_size_t a;
        a = ASZ_16;
        if (d_flag ^ pfx) begin
            a = ASZ_32;
        end
        return a;
    endfunction

    // Address size in flat mode. The prefix drops to 32 bits; there is no
    // 16-bit form here, so the decoder cannot ask for one by mistake.
    function automatic addr_size_t flat_asz(input logic pfx);
        addr_size_t a;
        a = ASZ_64;
        if (pfx) begin
            a = ASZ_32;
        end
        return a;
    endfunction

    // True when the base register is the stack or frame pointer; such a base
    // pulls the default segment over to the stack segment.
    function automatic logic is_stack_base(input logic valid, input logic [3:0] idx);
        logic hit;
        hit = 1'b0;
        if (valid) begin
            hit = (idx == GPR_IDX_SP) || (idx == GPR_IDX_FP);
        end
        return hit;
    endfunction

    // Index times scale. Every multiplier is a power of two, so a shift does
    // the work and a negative index keeps its sign in two's complement.
    // The scale field itself is an unsigned shift count.
    function automatic logic [63:0] scale_index(input logic [63:0] v, input logic [1:0] s);
        logic [63:0] r;
        r = v;
        case (s)
            2'h0: r = v;
            2'h1: r = {v[62:0], 1'h0};
            2'h2: r = {v[61:0], 2'h0};
            2'h3: r = {v[60:0], 3'h0};
            default: r = v;
        endcase
        return r;
    endfunction

    // Offset half of a far pointer: the doubleword at the lower address.
    // The pointer arrives little end first, so that is the low 32 bits.
    function automatic logic [31:0] far_ofs(input logic [47:0] p);
        return p[FAR_OFS_W-1:0];
    endfunction

    // Selector half of a far pointer: the word that follows the offset.
    // Only the top 16 bits of the 48-bit pointer hold it.
    function automatic logic [15:0] far_sel(input logic [47:0] p);
        return p[FAR_PTR_W-1:FAR_OFS_W];
    endfunction

    addr_size_t asz_comb;
    logic [63:0] seg_base_sel;
    logic stack_base;
    logic rsp_valid_reg;
    agen_rsp_t rsp_reg;
    agen_rsp_t rsp_next;
    logic sel_out_valid_reg;
    logic [15:0] sel_out_reg;
    logic [15:0] sel_out_next;
    logic [31:0] far_offset_reg;
    logic [31:0] far_offset_next;
    seg_sel_t seg_comb;
    logic [63:0] disp_ext;
    logic [63:0] base_term;
    logic [63:0] index_term;
    logic [63:0] ea_sum;
    logic [63:0] ea_comb;
    logic [63:0] lin_comb;
    logic bad_index_comb;
    logic flat;

    assign flat = (req.mode == MODE_FLAT);

    // A relative reference has no base register, so it never picks the stack.
    // Outside flat mode the relative flag is ignored and the base counts.
    assign stack_base = is_stack_base(req.base_valid && !(req.ip_rel && flat), req.base_idx);

    // Effective address size. Compatibility mode uses the same table as
    // legacy protected operation, keyed on the code segment default flag.
    always_comb begin
        if (flat) begin
            asz_comb = flat_asz(req.asz_prefix);
        end else begin
            asz_comb = legacy_asz(req.code_d_flag, req.asz_prefix);
        end
    end

    // Segment choice; fixed defaults win over any override prefix.
    always_comb begin
        seg_comb = SEG_DATA;
        case (req.kind)
            REF_FETCH: seg_comb = SEG_CODE;
            REF_STACK: seg_comb = SEG_STACK;
            REF_STR_DST: seg_comb = SEG_EXTRA;
            REF_DATA: begin
                if (req.ovr_valid) begin
                    seg_comb = req.ovr_seg;
                end else if (stack_base) begin
                    seg_comb = SEG_STACK;
                end else begin
                    seg_comb = SEG_DATA;
                end
            end
            default: seg_comb = SEG_DATA;
        endcase
    end

    // Offset components. The stack pointer as index is refused and flagged;
    // the index term is then dropped so the sum stays well defined.
    always_comb begin
        bad_index_comb = req.index_valid && (req.index_idx == GPR_IDX_SP);
        disp_ext = sext_disp(req.disp_size, req.disp);
        base_term = 64'h0;
        index_term = 64'h0;
        if (req.ip_rel && flat) begin
            disp_ext = {{32{req.disp[31]}}, req.disp};
            base_term = req.next_ip;
        end else begin
            if (req.base_valid) begin
                base_term = sized_reg(asz_comb, gpr_val[req.base_idx]);
            end
            if (req.index_valid && !bad_index_comb) begin
                index_term = scale_index(sized_reg(asz_comb, gpr_val[req.index_idx]),
                                         req.scale_log2);
            end
        end
        ea_sum = disp_ext + base_term + index_term;
        ea_comb = ea_sum & size_mask(asz_comb);
    end

    // Base of the chosen segment. Codes above the six segment registers read
    // as zero, so an illegal override code cannot index past the table end.
    // Such a code is a decoder fault; the address it gives is meaningless.
    always_comb begin
        seg_base_sel = 64'h0;
        if (seg_comb <= SEG_AUX_B) begin
            seg_base_sel = seg_base[seg_comb];
        end
    end

    // Linear address. Flat mode zeroes all bases except the auxiliary pair.
    // Outside flat mode the sum wraps at 32 bits like legacy hardware.
    always_comb begin
        if (flat) begin
            if (seg_comb == SEG_AUX_A || seg_comb == SEG_AUX_B) begin
                lin_comb = ea_comb + seg_base_sel;
            end else begin
                lin_comb = ea_comb;
            end
        end else begin
            lin_comb = (ea_comb + seg_base_sel) & MASK_32;
        end
    end

    // Next response word. The previous answer is kept while no request is
    // taken, so the memory stage may read it late without a copy of its own.
    always_comb begin
        rsp_next = rsp_reg;
        if (req_valid) begin
            rsp_next.seg = seg_comb;
            rsp_next.asz = asz_comb;
            rsp_next.eff_addr = ea_comb;
            rsp_next.lin_addr = lin_comb;
            rsp_next.bad_index = bad_index_comb;
        end
    end

    // Response strobe: one cycle after each taken request, never stretched.
    // Back to back requests give back to back strobes.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid_reg <= 1'b0;
        end else begin
            rsp_valid_reg <= req_valid;
        end
    end

    // Response word register. It loads every cycle; the hold on idle
    // cycles lives in the next-value logic above.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rsp_reg <= '0;
        end else begin
            rsp_reg <= rsp_next;
        end
    end

    // Next selector. A far load takes the word after the offset doubleword;
    // otherwise the selector comes from a register or from memory.
    always_comb begin
        sel_out_next = sel_out_reg;
        if (sel_valid) begin
            if (sel_req.far_valid) begin
                sel_out_next = far_sel(sel_req.far_mem);
            end else if (sel_req.from_reg) begin
                sel_out_next = sel_req.sel_reg_val;
            end else begin
                sel_out_next = sel_req.sel_mem_val;
            end
        end
    end

    // Next far offset. Only a far load moves it; a plain selector load
    // leaves the last offset in place.
    always_comb begin
        far_offset_next = far_offset_reg;
        if (sel_valid && sel_req.far_valid) begin
            far_offset_next = far_ofs(sel_req.far_mem);
        end
    end

    // Selector strobe: one cycle after each selector request.
    // It says nothing about whether the far offset moved.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sel_out_valid_reg <= 1'b0;
        end else begin
            sel_out_valid_reg <= sel_valid;
        end
    end

    // Selector register. It holds between requests so a later stage may
    // load a segment register from it at its own pace.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sel_out_reg <= 16'h0;
        end else begin
            sel_out_reg <= sel_out_next;
        end
    end

    // Far offset register. Kept apart from the selector because it moves
    // on far loads only.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            far_offset_reg <= 32'h0;
        end else begin
            far_offset_reg <= far_offset_next;
        end
    end

    // Outputs come straight from the registers above, with no logic after
    // them, so the memory stage sees clean timing.
    assign rsp_valid = rsp_valid_reg;
    assign rsp = rsp_reg;
    assign sel_out_valid = sel_out_valid_reg;
    assign sel_out = sel_out_reg;
    assign far_offset = far_offset_reg;

endmodule

`default_nettype wire

// *** verification/reg_file_model.sv ***
// Register file model feeding general registers and segment bases.
`timescale 1ns/1ps
`default_nettype none
module reg_file_model
    import agen_pkg::*;
(
    output logic [63:0] gpr_val [GPR_COUNT],
    output logic [63:0] seg_base [SEG_COUNT]
);
    // Register six is negative so that signed sums are exercised.
    always_comb begin
        for (int i = 0; i < GPR_COUNT; i++) begin
            gpr_val[i] = 64'(i) << 12;
        end
        gpr_val[6] = 64'hffff_ffff_ffff_fff0;
        for (int s = 0; s < SEG_COUNT; s++) begin
            seg_base[s] = 64'(s + 1) << 20;
        end
    end
endmodule
`default_nettype wire

// *** verification/seg_ea_gen_properties.sv ***
// Checker for the segment and effective address generator.
`timescale 1ns/1ps
`default_nettype none
module seg_ea_gen_chk
    import agen_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire agen_req_t req,
    input wire logic sel_valid,
    input wire sel_req_t sel_req,
    input wire logic rsp_valid,
    input wire agen_rsp_t rsp,
    input wire logic sel_out_valid,
    input wire logic [15:0] sel_out,
    input wire logic [31:0] far_offset
);
    default clocking dc @(posedge clock); endclocking
    default disable iff (!rst_n);
    // A request of one kind taken at this edge.
    sequence s_req(ref_kind_t k);
        req_valid && req.kind == k;
    endsequence
    a_rsp_pulse: assert property (rsp_valid == $past(req_valid))
        else $error("rsp_valid not one cycle after request");
    a_fetch_code: assert property (s_req(REF_FETCH) |=> rsp.seg == SEG_CODE)
        else $error("fetch not on code segment");
    a_stack_seg: assert property (s_req(REF_STACK) |=> rsp.seg == SEG_STACK)
        else $error("stack op not on stack segment");
    a_str_extra: assert property (s_req(REF_STR_DST) |=> rsp.seg == SEG_EXTRA)
        else $error("string destination not on extra segment");
    a_ovr_taken: assert property (s_req(REF_DATA) ##0 req.ovr_valid |=>
        rsp.seg == $past(req.ovr_seg)) else $error("override not applied");
    a_sp_index: assert property (req_valid && req.index_valid &&
        req.index_idx == GPR_IDX_SP |=> rsp.bad_index) else $error("sp index accepted");
    a_flat_zero: assert property (req_valid && req.mode == MODE_FLAT &&
        req.kind != REF_DATA |=> rsp.lin_addr == rsp.eff_addr) else $error("flat base not zero");
    a_flat_asz: assert property (req_valid && req.mode == MODE_FLAT |=>
        rsp.asz == ($past(req.asz_prefix) ? ASZ_32 : ASZ_64)) else $error("flat size wrong");
    a_ea_trunc: assert property (rsp_valid && rsp.asz != ASZ_64 |-> (rsp.eff_addr &
        ~(rsp.asz == ASZ_16 ? MASK_16 : MASK_32)) == 64'h0) else $error("address not truncated");
    a_far_pair: assert property (sel_valid && sel_req.far_valid |=>
        {sel_out, far_offset} == $past(sel_req.far_mem)) else $error("far pointer split wrong");
    a_sel_pulse: assert property (sel_out_valid == $past(sel_valid))
        else $error("sel_out_valid not one cycle after request");
    a_base_stack: assert property (s_req(REF_DATA) ##0 (!req.ovr_valid && req.base_valid &&
        (req.base_idx == GPR_IDX_SP || req.base_idx == GPR_IDX_FP) &&
        !(req.ip_rel && req.mode == MODE_FLAT)) |=> rsp.seg == SEG_STACK)
        else $error("stack base not on stack segment");
endmodule
bind seg_ea_gen seg_ea_gen_chk u_chk (
    .clock(clock),
    .rst_n(rst_n),
    .req_valid(req_valid),
    .req(req),
    .sel_valid(sel_valid),
    .sel_req(sel_req),
    .rsp_valid(rsp_valid),
    .rsp(rsp),
    .sel_out_valid(sel_out_valid),
    .sel_out(sel_out),
    .far_offset(far_offset)
);
`default_nettype wire

// *** verification/seg_ea_gen_test.sv ***
// Self-checking testbench for the segment and effective address generator.
`timescale 1ns/1ps
`default_nettype none
module seg_ea_gen_test
    import agen_pkg::*;
;
    typedef struct packed {
        agen_req_t r;
        agen_rsp_t e;
    } row_t;
    logic clock, rst_n, req_valid, sel_valid, rsp_valid, sel_out_valid;
    agen_req_t req;
    agen_rsp_t rsp;
    sel_req_t sel_req;
    logic [15:0] sel_out;
    logic [31:0] far_offset;
    logic [63:0] gpr_val [GPR_COUNT];
    logic [63:0] seg_base [SEG_COUNT];
    int n_fail = 0;
    int num_checks = 0;
    int cyc = 0;
    // Requests beside the responses they must give.
    row_t rows [8] = '{
        '{'{REF_FETCH, MODE_LEGACY, 1, 0, 1, SEG_AUX_A, 1, 3, 0, 0, 0, DISP_8, 32'h10, 0, 0},
          '{SEG_CODE, ASZ_32, 64'h3010, 64'h20_3010, 0}},
        '{'{REF_STACK, MODE_LEGACY, 1, 0, 1, SEG_AUX_B, 0, 0, 0, 0, 0, DISP_NONE, 0, 0, 0},
          '{SEG_STACK, ASZ_32, 64'h0, 64'h30_0000, 0}},
        '{'{REF_DATA, MODE_COMPAT, 0, 0, 0, SEG_DATA, 1, 5, 0, 0, 0, DISP_16, 32'hfffe, 0, 0},
          '{SEG_STACK, ASZ_16, 64'h4ffe, 64'h30_4ffe, 0}},
        '{'{REF_STR_DST, MODE_FLAT, 0, 0, 1, SEG_DATA, 1, 3, 1, 2, 3, DISP_NONE, 0, 0, 0},
          '{SEG_EXTRA, ASZ_64, 64'h1_3000, 64'h1_3000, 0}},
        '{'{REF_DATA, MODE_FLAT, 0, 0, 1, SEG_AUX_A, 1, 6, 1, 15, 0, DISP_8, 32'hf8, 0, 0},
          '{SEG_AUX_A, ASZ_64, 64'hefe8, 64'h50_efe8, 0}},
        '{'{REF_DATA, MODE_FLAT, 0, 0, 0, SEG_DATA, 0, 0, 0, 0, 0, DISP_32, 32'hffff_fff0, 1,
          64'h1_0000_0000}, '{SEG_DATA, ASZ_64, 64'hffff_fff0, 64'hffff_fff0, 0}},
        '{'{REF_DATA, MODE_FLAT, 0, 1, 0, SEG_DATA, 1, 6, 0, 0, 0, DISP_8, 32'h08, 0, 0},
          '{SEG_DATA, ASZ_32, 64'hffff_fff8, 64'hffff_fff8, 0}},
        '{'{REF_DATA, MODE_LEGACY, 0, 1, 0, SEG_DATA, 1, 3, 1, 4, 1, DISP_NONE, 0, 0, 0},
          '{SEG_DATA, ASZ_32, 64'h3000, 64'h40_3000, 1}}
    };
    always #25 clock = ~clock;
    reg_file_model u_rf (.gpr_val(gpr_val), .seg_base(seg_base));
    seg_ea_gen u_dut (.clock(clock), .rst_n(rst_n), .req_valid(req_valid), .req(req),
        .gpr_val(gpr_val), .seg_base(seg_base), .sel_valid(sel_valid), .sel_req(sel_req),
        .rsp_valid(rsp_valid), .rsp(rsp), .sel_out_valid(sel_out_valid), .sel_out(sel_out),
        .far_offset(far_offset));
    // Compare with case inequality so an unknown never matches.
    task automatic chk(input string n, input logic [134:0] s, input logic [134:0] e);
        num_checks++;
        if (s !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    // One request pulse; returns in the cycle where the answer stands.
    task automatic go(input agen_req_t r);
        @(posedge clock);
        #2;
        req = r;
        req_valid = 1'b1;
        @(posedge clock);
        #2;
        req_valid = 1'b0;
    endtask
    task automatic sgo(input sel_req_t s);
        @(posedge clock);
        #2;
        sel_req = s;
        sel_valid = 1'b1;
        @(posedge clock);
        #2;
        sel_valid = 1'b0;
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Ceiling well above the roughly 45 cycles the tests need.
    always @(posedge clock) begin
        cyc++;
        if (cyc == 2000) begin
            n_fail++;
            conclude();
        end
    end
    // Main sequence: reset, table, then the awkward cases.
    initial begin
        clock = 1'b0;
        rst_n = 1'b0;
        req_valid = 1'b0;
        sel_valid = 1'b0;
        req = '0;
        sel_req = '0;
        repeat (16) @(posedge clock);
        #2;
        chk("rsp reset", {rsp_valid, rsp}, '0);
        chk("sel reset", {sel_out_valid, sel_out, far_offset}, '0);
        rst_n = 1'b1;
        $display("test reset done");
        foreach (rows[i]) begin
            go(rows[i].r);
            chk("rsp_valid", rsp_valid, 1'b1);
            chk("rsp", rsp, rows[i].e);
        end
        $display("test table done");
        // Back to back requests, then the answer must hold.
        @(posedge clock);
        #2;
        req = rows[0].r;
        req_valid = 1'b1;
        go(rows[7].r);
        chk("b2b rsp", rsp, rows[7].e);
        @(posedge clock);
        #2;
        chk("held rsp", {rsp_valid, rsp}, {1'b0, rows[7].e});
        // Reset in mid-run clears outputs and the block recovers.
        rst_n = 1'b0;
        #10;
        chk("mid reset", rsp, '0);
        @(posedge clock);
        #2;
        rst_n = 1'b1;
        go(rows[2].r);
        chk("after reset", rsp, rows[2].e);
        $display("test back to back done");
        sgo('{1'b0, 16'h0, 16'h0, 1'b1, 48'habcd_1122_3344});
        chk("far pair", {sel_out_valid, sel_out, far_offset}, 49'h1_abcd_1122_3344);
        sgo('{1'b1, 16'h1234, 16'h5678, 1'b0, 48'h0});
        chk("reg sel", sel_out, 16'h1234);
        sgo('{1'b0, 16'h1234, 16'h5678, 1'b0, 48'h0});
        chk("mem sel", {sel_out, far_offset}, 48'h5678_1122_3344);
        $display("test selector done");
        conclude();
    end
endmodule
`default_nettype wire
